// *** verilog/dcd_pkg.sv ***
// Function
// - skip bit 0 clocks from the multiplier, 1 clocks directly from the supplied clock.
// - writing 1 to bias_shutdown (bit 7) powers the internal bias down; it resets to 0.
// - delay_line_shutdown resets to 1; at 1 the line is down and bypassed, else up.
// - the loop enable bit resets to 0 with the controller off; writing 1 turns it on.
// - the read-only lock indicator returns 1 when the loop has locked, else 0; resets to 0.
// - the lock indicator is refreshed only on a 0-to-1 edge of the readback strobe bit.
// - a 0-to-1 edge of the apply strobe loads current settings and both fine delays.
// - modulator_halver_bypass at 1 bypasses the divide-by-two stage, at 0 keeps it.
// - the bypass bit is kept per main path; writes reach the copies the page bits pick, reads the lowest picked one.
package dcd_pkg;
  // ****************************************
  // register indices, byte address = 4 x index
  // ****************************************
  localparam logic [9:0] IDX_PAGE = 10'h008;
  localparam logic [9:0] IDX_CLK_SRC = 10'h095;
  localparam logic [9:0] IDX_BIAS = 10'h09A;
  localparam logic [9:0] IDX_DL_PWR = 10'h0C0;
  localparam logic [9:0] IDX_LOOP_CFG = 10'h0C1;
  localparam logic [9:0] IDX_LOCK_STAT = 10'h0C3;
  localparam logic [9:0] IDX_LOCK_RFSH = 10'h0C7;
  localparam logic [9:0] IDX_FINE_A = 10'h0CC;
  localparam logic [9:0] IDX_FINE_B = 10'h0CD;
  localparam logic [9:0] IDX_APPLY = 10'h0DB;
  localparam logic [9:0] IDX_MOD_OVR = 10'h0FF;
  localparam logic [9:0] IDX_CORE_HOLD = 10'h100;
  // ****************************************
  // writable bit masks and reset values
  // ****************************************
  localparam logic [7:0] MSK_BIT0 = 8'h01;
  localparam logic [7:0] MSK_BIAS = 8'h80;
  localparam logic [7:0] MSK_DL_PWR = 8'h31;
  localparam logic [7:0] MSK_LOOP_CFG = 8'hF9;
  localparam logic [7:0] MSK_FINE = 8'h3F;
  localparam logic [7:0] MSK_PAGE = 8'h03;
  localparam int BIT_HALVER = 1;
  localparam int BIT_BIAS = 7;
  localparam int BIT_PWR_A = 4;
  localparam int BIT_PWR_B = 5;
  localparam int BIT_MODE = 5;
  localparam int LSB_TUNE = 6;
  localparam int LSB_DIR = 3;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DL_PWR = 8'h31;
  localparam logic [7:0] RST_LOOP_CFG = 8'h70;
  localparam logic [7:0] RST_PAGE = 8'h03;
  localparam logic [7:0] RST_CORE_HOLD = 8'h01;
endpackage : dcd_pkg

// *** verilog/dcd_rise_detect.sv ***
`timescale 1ns/1ns
module dcd_rise_detect
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic level,
  output logic rise
);
  import dcd_pkg::*;
  logic last;
  // ****************************************
  // previous level of the strobe bit
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      last <= 1'b0;
    else
      last <= level;
  end
  // only a 0-to-1 change counts, a steady 1 does nothing
  assign rise = level & ~last;
endmodule : dcd_rise_detect

// *** verilog/dcd_paged_bit.sv ***
`timescale 1ns/1ns
module dcd_paged_bit
#(
  parameter int NPATH = 2
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [NPATH-1:0] page,
  input wire logic wdata,
  output logic [NPATH-1:0] bits,
  output logic rdata
);
  import dcd_pkg::*;
  if (NPATH < 1)
  begin : g_bad_npath
    $error("NPATH must be at least 1");
  end
  logic [NPATH-1:0] first_sel;
  // ****************************************
  // per-path copies, a write lands in every selected copy
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      bits <= '0;
    else if (wr_en)
      bits <= (bits & ~page) | ({NPATH{wdata}} & page);
  end
  // read returns the lowest selected copy; nothing selected reads 0
  assign first_sel = page & (~page + 1'b1);
  assign rdata = |(bits & first_sel);
endmodule : dcd_paged_bit

// *** verilog/dcd_clock_ctrl.sv ***
`timescale 1ns/1ns
module dcd_clock_ctrl
#(
  parameter int NPATH = 2
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic loop_locked_pin,
  output logic skip_multiplier,
  output logic bias_shutdown,
  output logic delay_line_shutdown,
  output logic delay_line_power_a,
  output logic delay_line_power_b,
  output logic delay_loop_enable,
  output logic [1:0] converter_tuning_field,
  output logic lock_search_mode,
  output logic [1:0] lock_search_direction,
  output logic [5:0] fine_delay_a,
  output logic [5:0] fine_delay_b,
  output logic delay_load,
  output logic [NPATH-1:0] modulator_halver_bypass,
  output logic core_logic_hold
);
  import dcd_pkg::*;

  // ****************************************
  // elaboration checks
  // ****************************************
  if (NPATH < 1 || NPATH > 2)
  begin : g_bad_npath
    $error("NPATH must be 1 or 2");
  end

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] clk_src;
  logic [7:0] bias;
  logic [7:0] dl_pwr;
  logic [7:0] loop_cfg;
  logic [7:0] lock_stat;
  logic [7:0] lock_rfsh;
  logic [7:0] fine_a;
  logic [7:0] fine_b;
  logic [7:0] apply;
  logic [7:0] page;
  logic [7:0] core_hold;
  logic lock_meta;
  logic lock_sync;
  logic rfsh_rise;
  logic apply_rise;
  logic halver_rd;
  logic [7:0] next_rdata;
  logic next_err;
  logic [31:0] rdata_q;
  logic err_q;

  // ****************************************
  // bus decode
  // ****************************************
  wire [9:0] idx = paddr[11:2];
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire aligned = paddr[1:0] == 2'b00;
  wire hit_clk = aligned & (idx == IDX_CLK_SRC);
  wire hit_bias = aligned & (idx == IDX_BIAS);
  wire hit_dl = aligned & (idx == IDX_DL_PWR);
  wire hit_cfg = aligned & (idx == IDX_LOOP_CFG);
  wire hit_stat = aligned & (idx == IDX_LOCK_STAT);
  wire hit_rfsh = aligned & (idx == IDX_LOCK_RFSH);
  wire hit_fa = aligned & (idx == IDX_FINE_A);
  wire hit_fb = aligned & (idx == IDX_FINE_B);
  wire hit_app = aligned & (idx == IDX_APPLY);
  wire hit_mod = aligned & (idx == IDX_MOD_OVR);
  wire hit_page = aligned & (idx == IDX_PAGE);
  wire hit_hold = aligned & (idx == IDX_CORE_HOLD);
  wire mapped = hit_clk | hit_bias | hit_dl | hit_cfg | hit_stat | hit_rfsh
              | hit_fa | hit_fb | hit_app | hit_mod | hit_page | hit_hold;
  // writes commit only at the access edge; the status register is read-only
  wire wr = access & pwrite & mapped;
  wire [7:0] wd = pwdata[7:0];

  // merge helper: masked bits take the write, reserved stay zero
  function automatic logic [7:0] dcd_merge(input logic [7:0] data, input logic [7:0] mask);
    dcd_merge = data & mask;
  endfunction : dcd_merge

  // ****************************************
  // lock pin synchroniser, it arrives from the analog loop
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end
    else
    begin
      lock_meta <= loop_locked_pin;
      lock_sync <= lock_meta;
    end
  end

  // ****************************************
  // writable control registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      clk_src <= RST_ZERO;
      bias <= RST_ZERO;
      dl_pwr <= RST_DL_PWR;
      loop_cfg <= RST_LOOP_CFG;
      lock_rfsh <= RST_ZERO;
      fine_a <= RST_ZERO;
      fine_b <= RST_ZERO;
      apply <= RST_ZERO;
      page <= RST_PAGE;
      core_hold <= RST_CORE_HOLD;
    end
    else if (wr)
    begin
      if (hit_clk)
        clk_src <= dcd_merge(wd, MSK_BIT0);
      if (hit_bias)
        bias <= dcd_merge(wd, MSK_BIAS);
      if (hit_dl)
        dl_pwr <= dcd_merge(wd, MSK_DL_PWR);
      if (hit_cfg)
        loop_cfg <= dcd_merge(wd, MSK_LOOP_CFG);
      if (hit_rfsh)
        lock_rfsh <= dcd_merge(wd, MSK_BIT0);
      if (hit_fa)
        fine_a <= dcd_merge(wd, MSK_FINE);
      if (hit_fb)
        fine_b <= dcd_merge(wd, MSK_FINE);
      if (hit_app)
        apply <= dcd_merge(wd, MSK_BIT0);
      if (hit_page)
        page <= dcd_merge(wd, MSK_PAGE);
      if (hit_hold)
        core_hold <= dcd_merge(wd, MSK_BIT0);
    end
  end

  // ****************************************
  // strobe edge detectors
  // ****************************************
  dcd_rise_detect u_rfsh_edge
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .level(lock_rfsh[0]),
    .rise(rfsh_rise)
  );

  dcd_rise_detect u_apply_edge
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .level(apply[0]),
    .rise(apply_rise)
  );

  // ****************************************
  // lock status, sampled only on the refresh edge
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      lock_stat <= RST_ZERO;
    else if (rfsh_rise)
      lock_stat <= {7'h00, lock_sync};
  end

  // ****************************************
  // settings handed to the loop on the apply edge
  // ****************************************
  // the loop sees only applied values except delay_loop_enable, which is direct, so partial writes never glitch the rest
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      fine_delay_a <= 6'h00;
      fine_delay_b <= 6'h00;
      converter_tuning_field <= RST_LOOP_CFG[LSB_TUNE +: 2];
      lock_search_mode <= RST_LOOP_CFG[BIT_MODE];
      lock_search_direction <= RST_LOOP_CFG[LSB_DIR +: 2];
      delay_load <= 1'b0;
    end
    else
    begin
      delay_load <= apply_rise;
      if (apply_rise)
      begin
        fine_delay_a <= fine_a[5:0];
        fine_delay_b <= fine_b[5:0];
        converter_tuning_field <= loop_cfg[LSB_TUNE +: 2];
        lock_search_mode <= loop_cfg[BIT_MODE];
        lock_search_direction <= loop_cfg[LSB_DIR +: 2];
      end
    end
  end

  // ****************************************
  // per-path modulator halver bypass
  // ****************************************
  dcd_paged_bit #(.NPATH(NPATH)) u_halver
  (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(wr & hit_mod),
    .page(page[NPATH-1:0]),
    .wdata(wd[BIT_HALVER]),
    .bits(modulator_halver_bypass),
    .rdata(halver_rd)
  );

  // ****************************************
  // static control outputs
  // ****************************************
  assign skip_multiplier = clk_src[0];
  assign bias_shutdown = bias[BIT_BIAS];
  assign delay_line_shutdown = dl_pwr[0];
  assign delay_line_power_a = dl_pwr[BIT_PWR_A];
  assign delay_line_power_b = dl_pwr[BIT_PWR_B];
  assign delay_loop_enable = loop_cfg[0];
  assign core_logic_hold = core_hold[0];

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    next_rdata = 8'h00;
    next_err = ~mapped;
    case (1'b1)
      hit_clk: next_rdata = clk_src;
      hit_bias: next_rdata = bias;
      hit_dl: next_rdata = dl_pwr;
      hit_cfg: next_rdata = loop_cfg;
      hit_stat: next_rdata = lock_stat;
      hit_rfsh: next_rdata = lock_rfsh;
      hit_fa: next_rdata = fine_a;
      hit_fb: next_rdata = fine_b;
      hit_app: next_rdata = apply;
      hit_mod: next_rdata = {6'h00, halver_rd, 1'b0};
      hit_page: next_rdata = page;
      hit_hold: next_rdata = core_hold;
      default: next_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // read data captured in setup, answered in access
  // ****************************************
  // one extra flop keeps prdata glitch free at the cost of no latency change
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (setup)
    begin
      rdata_q <= {24'h00_0000, next_rdata};
      err_q <= next_err;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = access & err_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_rfsh_edge;
    !lock_rfsh[0] ##1 lock_rfsh[0];
  endsequence

  sequence s_apply_edge;
    !apply[0] ##1 apply[0];
  endsequence

  property p_skip_follows;
    $past(wr & hit_clk) |-> skip_multiplier == $past(wd[0]);
  endproperty

  property p_dl_follows;
    wr & hit_dl |=> delay_line_shutdown == $past(wd[0]);
  endproperty

  property p_apply_load;
    s_apply_edge |=> delay_load && fine_delay_a == $past(fine_a[5:0]);
  endproperty

  // selected copies take the written bit, the others keep theirs
  property p_halver_page;
    wr & hit_mod |=> (modulator_halver_bypass & $past(page[NPATH-1:0]))
      == ({NPATH{$past(wd[BIT_HALVER])}} & $past(page[NPATH-1:0]));
  endproperty

  property p_halver_keep;
    wr & hit_mod |=> (modulator_halver_bypass & ~$past(page[NPATH-1:0]))
      == ($past(modulator_halver_bypass) & ~$past(page[NPATH-1:0]));
  endproperty

  // a bad address must be refused in the same access cycle
  property p_err_unmapped;
    access & ~mapped |-> pslverr;
  endproperty

  property p_rsvd_zero;
    access & !pwrite & !err_q |-> prdata[31:8] == 24'h0 && !(hit_dl && |prdata[3:1]);
  endproperty

  AST_SKIP_FOLLOWS: assert property (p_skip_follows)
    else $error("skip bit did not follow write");
  AST_BIAS_WRITE: assert property (wr & hit_bias & wd[BIT_BIAS] |=> bias_shutdown)
    else $error("bias not shut down after write");
  AST_DL_RESET: assert property ($fell(sys_rst) |-> delay_line_shutdown)
    else $error("delay line not shut down after reset");
  AST_DL_FOLLOWS: assert property (p_dl_follows)
    else $error("delay line shutdown did not follow write");
  AST_LOOP_RESET: assert property ($fell(sys_rst) |-> !delay_loop_enable)
    else $error("loop enabled after reset");
  AST_LOCK_REFRESH: assert property (s_rfsh_edge |=> lock_stat[0] == $past(lock_sync))
    else $error("lock indicator not refreshed on edge");
  AST_LOCK_STEADY: assert property (!rfsh_rise |=> $stable(lock_stat))
    else $error("lock indicator changed without refresh edge");
  AST_LOCK_ZERO_HI: assert property (1'b1 |-> lock_stat[7:1] == 7'h00)
    else $error("lock status upper bits set");
  AST_APPLY_LOAD: assert property (p_apply_load)
    else $error("fine delay not loaded on apply edge");
  AST_APPLY_HOLD: assert property (!apply_rise |=> $stable(fine_delay_b) && !delay_load)
    else $error("fine delay changed without apply edge");
  AST_HALVER_PAGE: assert property (p_halver_page)
    else $error("halver copy not written on selected page");
  AST_HALVER_KEEP: assert property (p_halver_keep)
    else $error("unselected halver copy changed");
  AST_ERR_UNMAPPED: assert property (p_err_unmapped)
    else $error("bad address not refused");
  AST_RSVD_ZERO: assert property (p_rsvd_zero)
    else $error("reserved bits read nonzero");
endmodule : dcd_clock_ctrl

// *** tb/dac_clock_delay_line_config_tb_top.sv ***
`timescale 1ns/1ns
// one comparison: counts it, reports and counts a mismatch
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module dac_clock_delay_line_config_tb_top;
  import dcd_pkg::*;
  // ****************************************
  // signals, clock and design instance
  // ****************************************
  localparam int LIMIT = 5000;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic loop_locked_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, skip_multiplier, bias_shutdown, delay_line_shutdown;
  logic delay_line_power_a, delay_line_power_b, delay_loop_enable, lock_search_mode;
  logic delay_load, core_logic_hold;
  logic [1:0] converter_tuning_field, lock_search_direction, modulator_halver_bypass;
  logic [5:0] fine_delay_a, fine_delay_b;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // register table walked by the reset and mask scenarios; apply last so it loads
  logic [9:0] idx_tab [0:10] = '{IDX_CLK_SRC, IDX_BIAS, IDX_DL_PWR, IDX_LOOP_CFG,
    IDX_LOCK_STAT, IDX_LOCK_RFSH, IDX_FINE_A, IDX_FINE_B, IDX_MOD_OVR, IDX_CORE_HOLD, IDX_APPLY};
  logic [7:0] msk_tab [0:10] = '{8'h01, 8'h80, 8'h31, 8'hF9, 8'h00, 8'h01, 8'h3F, 8'h3F,
    8'h02, 8'h01, 8'h01};
  logic [7:0] rst_tab [0:10] = '{8'h00, 8'h00, 8'h31, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h00};

  always #4 clock = ~clock;

  dcd_clock_ctrl #(.NPATH(2)) uut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_locked_pin(loop_locked_pin),
    .skip_multiplier(skip_multiplier), .bias_shutdown(bias_shutdown),
    .delay_line_shutdown(delay_line_shutdown), .delay_line_power_a(delay_line_power_a),
    .delay_line_power_b(delay_line_power_b), .delay_loop_enable(delay_loop_enable),
    .converter_tuning_field(converter_tuning_field), .lock_search_mode(lock_search_mode),
    .lock_search_direction(lock_search_direction), .fine_delay_a(fine_delay_a),
    .fine_delay_b(fine_delay_b), .delay_load(delay_load),
    .modulator_halver_bypass(modulator_halver_bypass), .core_logic_hold(core_logic_hold));

  // ****************************************
  // bus tasks
  // ****************************************
  // leading edge keeps release and next setup in different time steps
  task automatic apb_xfer(input logic [9:0] idx, input logic wr, input logic [7:0] wd,
    input logic [1:0] low, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, low};
    pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clock);
    end
    if (n == 50)
      errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    logic e;
    apb_xfer(idx, 1'b1, wd, 2'b00, d, e);
  endtask : wr

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic e;
    apb_xfer(idx, 1'b0, 8'h00, 2'b00, d, e);
    `CHK("read data", {24'h0, exp}, d)
    `CHK("read error", 1'b0, e)
  endtask : rd_chk

  // counts delay_load pulses seen over a short window after the last write
  task automatic count_loads(input int exp);
    int c;
    c = 0;
    repeat (6)
    begin
      @(negedge clock);
      if (delay_load === 1'b1)
        c++;
    end
    `CHK("load pulses", exp, c)
  endtask : count_loads

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    @(negedge clock);
    `CHK("skip", 1'b0, skip_multiplier)
    `CHK("bias", 1'b0, bias_shutdown)
    `CHK("dl shut", 1'b1, delay_line_shutdown)
    `CHK("dl pwr", 2'b11, {delay_line_power_b, delay_line_power_a})
    `CHK("mode", 1'b1, lock_search_mode)
    `CHK("loop en", 1'b0, delay_loop_enable)
    `CHK("hold", 1'b1, core_logic_hold)
    `CHK("tuning", 2'h1, converter_tuning_field)
    `CHK("direction", 2'h2, lock_search_direction)
    `CHK("fine a", 6'h00, fine_delay_a)
    `CHK("fine b", 6'h00, fine_delay_b)
    `CHK("load", 1'b0, delay_load)
    `CHK("halver", 2'b00, modulator_halver_bypass)
    for (int i = 0; i < 11; i++)
      rd_chk(idx_tab[i], rst_tab[i]);
    rd_chk(IDX_PAGE, 8'h03);
  endtask : test_reset

  // all ones then all zeros into every register but the page register; reserved bits must drop out
  task automatic test_masks;
    logic [7:0] v;
    for (int p = 0; p < 2; p++)
    begin
      v = (p == 0) ? 8'hFF : 8'h00;
      for (int i = 0; i < 11; i++)
        wr(idx_tab[i], v);
      for (int i = 0; i < 11; i++)
        rd_chk(idx_tab[i], v & msk_tab[i]);
      @(negedge clock);
      `CHK("skip", v[0], skip_multiplier)
      `CHK("bias", v[7], bias_shutdown)
      `CHK("dl shut", v[0], delay_line_shutdown)
      `CHK("dl pwr", {v[5], v[4]}, {delay_line_power_b, delay_line_power_a})
      `CHK("loop en", v[0], delay_loop_enable)
      `CHK("halver", {2{v[1]}}, modulator_halver_bypass)
      `CHK("hold", v[0], core_logic_hold)
    end
  endtask : test_masks

  task automatic test_lock;
    @(posedge clock);
    loop_locked_pin <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(IDX_LOCK_STAT, 8'h00);
    wr(IDX_LOCK_RFSH, 8'h01);
    rd_chk(IDX_LOCK_STAT, 8'h01);
    @(posedge clock);
    loop_locked_pin <= 1'b0;
    repeat (4) @(posedge clock);
    wr(IDX_LOCK_RFSH, 8'h01);
    rd_chk(IDX_LOCK_STAT, 8'h01);
    wr(IDX_LOCK_STAT, 8'hFF);
    wr(IDX_LOCK_RFSH, 8'h00);
    wr(IDX_LOCK_RFSH, 8'h01);
    rd_chk(IDX_LOCK_STAT, 8'h00);
  endtask : test_lock

  // settings loaded by the all-ones pass stay until the next apply edge
  task automatic test_apply;
    wr(IDX_FINE_A, 8'h2A);
    wr(IDX_FINE_B, 8'h15);
    wr(IDX_LOOP_CFG, 8'h89);
    @(negedge clock);
    `CHK("loop en", 1'b1, delay_loop_enable)
    `CHK("fine a", 6'h3F, fine_delay_a)
    `CHK("tuning", 2'h3, converter_tuning_field)
    wr(IDX_APPLY, 8'h01);
    count_loads(1);
    `CHK("fine a", 6'h2A, fine_delay_a)
    `CHK("fine b", 6'h15, fine_delay_b)
    `CHK("tuning", 2'h2, converter_tuning_field)
    `CHK("mode", 1'b0, lock_search_mode)
    `CHK("direction", 2'h1, lock_search_direction)
    wr(IDX_APPLY, 8'h01);
    count_loads(0);
    // recommended tuning and direction, slow converter clock search mode
    wr(IDX_APPLY, 8'h00);
    wr(IDX_LOOP_CFG, 8'h48);
    wr(IDX_APPLY, 8'h01);
    count_loads(1);
    `CHK("tuning", 2'h1, converter_tuning_field)
    `CHK("direction", 2'h1, lock_search_direction)
    `CHK("mode", 1'b0, lock_search_mode)
  endtask : test_apply

  task automatic test_page;
    logic [31:0] d;
    logic e;
    wr(IDX_PAGE, 8'h01);
    wr(IDX_MOD_OVR, 8'h02);
    @(negedge clock);
    `CHK("halver", 2'b01, modulator_halver_bypass)
    wr(IDX_PAGE, 8'h02);
    rd_chk(IDX_MOD_OVR, 8'h00);
    wr(IDX_MOD_OVR, 8'h02);
    wr(IDX_PAGE, 8'h00);
    wr(IDX_MOD_OVR, 8'h00);
    @(negedge clock);
    `CHK("halver", 2'b11, modulator_halver_bypass)
    wr(IDX_PAGE, 8'h03);
    wr(IDX_MOD_OVR, 8'h00);
    @(negedge clock);
    `CHK("halver", 2'b00, modulator_halver_bypass)
    apb_xfer(10'h0C2, 1'b0, 8'h00, 2'b00, d, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, d)
    apb_xfer(IDX_CLK_SRC, 1'b1, 8'h01, 2'b01, d, e);
    @(negedge clock);
    `CHK("misaligned err", 1'b1, e)
    `CHK("skip", 1'b0, skip_multiplier)
  endtask : test_page

  // reset in mid-run must bring registers and applied settings back
  task automatic test_midrun_reset;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
  endtask : test_midrun_reset

  // ****************************************
  // verdict, timeout and main sequence
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // a hung handshake ends here rather than running forever
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
    test_masks();
    test_lock();
    test_apply();
    test_page();
    test_midrun_reset();
    finish_test();
  end
endmodule : dac_clock_delay_line_config_tb_top
